// ==== rtl/scfr_pkg.sv ====
// Purpose: shared constants of the serial character framing receiver
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: one aligned word per register

package scfr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADR_W = 5;
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_SYNC = 5'h04;
  localparam logic [4:0] ADR_DATA = 5'h08;
  localparam logic [4:0] ADR_STAT = 5'h0c;
  localparam logic [4:0] ADR_ISTS = 5'h10;
  localparam logic [4:0] ADR_IMSK = 5'h14;
  localparam logic [4:0] ADR_BAUD = 5'h18;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CHAR_W = 8;
  localparam int BAUD_W = 16;
  localparam int CTRL_HUNT = 0;
  localparam int CTRL_TWO = 1;
  localparam int STAT_AVAIL = 0;
  localparam int STAT_SYNCED = 1;
  localparam int STAT_MODE = 2;
  localparam int IRQ_W = 3;
  localparam int IRQ_CHR = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_SYN = 2;
  localparam logic [7:0] SYNC_RST = 8'h16;
  localparam logic TWO_RST = 1'b0;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

endpackage

// ==== rtl/scfr_lane_if.sv ====
// Purpose: carries one framing engine's line input and character output
// Assumes: single clock domain, ref_clk
// Notes: one instance per engine

`timescale 1ns/1ps

interface scfr_lane_if;
  logic line;
  logic clr;
  logic stb;
  logic [7:0] chr;
  modport eng (input line, input clr, output stb, output chr);
  modport top (output line, output clr, input stb, input chr);
endinterface

// ==== rtl/scfr_async_rx.sv ====
// Purpose: asynchronous start-bit framing of eight data bits
// Assumes: line already synchronised to ref_clk
// Notes: first arrived bit ends in chr[7]

`timescale 1ns/1ps

module scfr_async_rx
  import scfr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Engine lane and bit period in cycles
  scfr_lane_if.eng lane,
  input wire logic [scfr_pkg::BAUD_W-1:0] bit_cyc
);
  import scfr_pkg::*;

  typedef enum logic [1:0] {
    AS_IDLE = 2'b00,
    AS_START = 2'b01,
    AS_DATA = 2'b10,
    AS_MARK = 2'b11
  } scfr_as_t;

  scfr_as_t st_reg;
  logic prev_reg;
  logic [BAUD_W-1:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [7:0] sh_reg;
  logic stb_reg;
  wire tick = (cnt_reg == '0);
  wire fall = prev_reg & ~lane.line;
  wire [7:0] sh_next = {sh_reg[6:0], lane.line};

  assign lane.stb = stb_reg;
  assign lane.chr = sh_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= AS_IDLE;
      prev_reg <= 1'b1;
      cnt_reg <= '0;
      bit_reg <= 3'h0;
      sh_reg <= 8'h00;
      stb_reg <= 1'b0;
    end else begin
      prev_reg <= lane.line;
      stb_reg <= 1'b0;
      cnt_reg <= tick ? cnt_reg : cnt_reg - 1'b1;
      if (lane.clr) begin
        st_reg <= AS_IDLE;
      end else begin
        unique case (st_reg)
          AS_IDLE: if (fall) begin
            st_reg <= AS_START;
            cnt_reg <= bit_cyc >> 1;
          end
          AS_START: if (tick) begin
            // A glitch shorter than half a bit is not a start
            st_reg <= lane.line ? AS_IDLE : AS_DATA;
            cnt_reg <= bit_cyc - 1'b1;
            bit_reg <= 3'h0;
          end
          AS_DATA: if (tick) begin
            sh_reg <= sh_next;
            cnt_reg <= bit_cyc - 1'b1;
            bit_reg <= bit_reg + 1'b1;
            if (bit_reg == BIT_LAST) begin
              st_reg <= AS_MARK;
              stb_reg <= 1'b1;
            end
          end
          AS_MARK: if (lane.line) begin
            st_reg <= AS_IDLE;
          end
        endcase
      end
    end
  end

endmodule // scfr_async_rx

// ==== rtl/scfr_sync_rx.sv ====
// Purpose: sync-character hunt and eight-bit framing
// Assumes: bit_stb marks the receive clock sample instant
// Notes: first arrived bit ends in chr[7]

`timescale 1ns/1ps

module scfr_sync_rx
  import scfr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Engine lane
  scfr_lane_if.eng lane,
  // Framing control
  input wire logic bit_stb,
  input wire logic [7:0] sync_chr,
  input wire logic two_sync,
  // State
  output logic synced
);
  import scfr_pkg::*;

  typedef enum logic [1:0] {
    SY_HUNT = 2'b00,
    SY_SECOND = 2'b01,
    SY_FRAMED = 2'b10
  } scfr_sy_t;

  scfr_sy_t st_reg;
  logic [7:0] sh_reg;
  logic [2:0] cnt_reg;
  logic stb_reg;
  wire [7:0] sh_next = {sh_reg[6:0], lane.line};
  wire match = (sh_next == sync_chr);
  wire full = (cnt_reg == BIT_LAST);

  assign lane.stb = stb_reg;
  assign lane.chr = sh_reg;
  assign synced = (st_reg == SY_FRAMED);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= SY_HUNT;
      sh_reg <= 8'h00;
      cnt_reg <= 3'h0;
      stb_reg <= 1'b0;
    end else begin
      stb_reg <= 1'b0;
      if (lane.clr) begin
        st_reg <= SY_HUNT;
        cnt_reg <= 3'h0;
      end else if (bit_stb) begin
        sh_reg <= sh_next;
        cnt_reg <= cnt_reg + 1'b1;
        unique case (st_reg)
          SY_HUNT: if (match) begin
            // Count restarts so the next word is on the sync boundary
            st_reg <= two_sync ? SY_SECOND : SY_FRAMED;
            cnt_reg <= 3'h0;
          end
          SY_SECOND: if (full) begin
            st_reg <= match ? SY_FRAMED : SY_HUNT;
          end
          SY_FRAMED: if (full) begin
            stb_reg <= 1'b1;
          end
          default: st_reg <= SY_HUNT;
        endcase
      end
    end
  end

endmodule // scfr_sync_rx

// ==== rtl/scfr_top.sv ====
// Purpose: serial character framing receiver with Wishbone registers
// Assumes: ref_clk 125 MHz, rx pins asynchronous to it
// Notes: one interrupt line; interrupt status bits are write-one-to-clear
//
// Contract
// - Async receiver finds the falling edge, rechecks zero at half bit.
// - Eight samples one bit apart form the async character.
// - Sync mode samples data at the instant the receive clock marks.
// - Sync hunt on start, and on hardware or software resync command.
// - Hunt compares the last eight bits with a loadable sync character.
// - On a miss, shift one more bit and compare again.
// - After sync, flag a character every eight further bits.
// - Optionally require two successive sync characters before framing.

`timescale 1ns/1ps

module scfr_top
  import scfr_pkg::*;
#(
  parameter logic [scfr_pkg::BAUD_W-1:0] BIT_CYC = 16'h043d
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [scfr_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial line
  input wire logic rx_data,
  input wire logic rx_clk,
  // Host logic
  input wire logic mode_sync,
  input wire logic hunt_req,
  // Interrupt
  output logic irq
);
  import scfr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Stage one feeds stage two only; edges are found past stage two
  logic [2:0] dat_s1_reg;
  logic [2:0] dat_s2_reg;
  logic clk_prev_reg;
  logic mode_prev_reg;
  wire [2:0] pins = {mode_sync, rx_clk, rx_data};
  wire line_s = dat_s2_reg[0];
  wire rclk_s = dat_s2_reg[1];
  wire mode_s = dat_s2_reg[2];

  // Reset levels match the idle pins, so no false edge follows reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dat_s1_reg <= 3'h1;
      dat_s2_reg <= 3'h1;
      clk_prev_reg <= 1'b0;
      mode_prev_reg <= 1'b0;
    end else begin
      dat_s1_reg <= pins;
      dat_s2_reg <= dat_s1_reg;
      clk_prev_reg <= rclk_s;
      mode_prev_reg <= mode_s;
    end
  end

  // Rising receive clock is the sample instant
  wire bit_stb = rclk_s & ~clk_prev_reg;
  wire mode_chg = mode_s ^ mode_prev_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Registered ack: one wait state; acc masks the cycle in which ack stands
  logic ack_reg;
  wire acc = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr = acc & wb_we_i;
  wire rd = acc & ~wb_we_i;
  // Full decode: unmapped offsets read zero and ignore writes
  wire sel_ctrl = (wb_adr_i == ADR_CTRL);
  wire sel_sync = (wb_adr_i == ADR_SYNC);
  wire sel_data = (wb_adr_i == ADR_DATA);
  wire sel_stat = (wb_adr_i == ADR_STAT);
  wire sel_ists = (wb_adr_i == ADR_ISTS);
  wire sel_imsk = (wb_adr_i == ADR_IMSK);
  wire sel_baud = (wb_adr_i == ADR_BAUD);
  wire wr_b0 = wr & wb_sel_i[0];
  wire wr_b1 = wr & wb_sel_i[1];
  wire [7:0] wdat_b0 = wb_dat_i[7:0];
  wire [7:0] wdat_b1 = wb_dat_i[15:8];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic two_reg;
  logic [7:0] sync_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic [IRQ_W-1:0] imsk_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      two_reg <= TWO_RST;
      sync_reg <= SYNC_RST;
      imsk_reg <= IRQ_RST;
    end else begin
      if (wr_b0 && sel_ctrl) begin
        two_reg <= wb_dat_i[CTRL_TWO];
      end
      if (wr_b0 && sel_sync) begin
        sync_reg <= wdat_b0;
      end
      if (wr_b0 && sel_imsk) begin
        imsk_reg <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // A new bit period applies at once; change it only while the line idles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      baud_reg <= BIT_CYC;
    end else begin
      if (wr_b0 && sel_baud) begin
        baud_reg[7:0] <= wdat_b0;
      end
      if (wr_b1 && sel_baud) begin
        baud_reg[15:8] <= wdat_b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Engine restart
  // ----------------------------------------------------------------

  // Software hunt command is a self-clearing pulse
  wire sw_hunt = wr_b0 & sel_ctrl & wb_dat_i[CTRL_HUNT];
  logic boot_reg;
  // Restart both engines after reset, on a mode change or on command
  wire restart = boot_reg | mode_chg | sw_hunt | hunt_req;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Framing engines
  // ----------------------------------------------------------------
  scfr_lane_if a_lane ();
  scfr_lane_if s_lane ();
  // Both engines run at all times; a mode change restarts both, so the sync engine hunts again
  logic synced;

  assign a_lane.line = line_s;
  assign a_lane.clr = restart;
  assign s_lane.line = line_s;
  assign s_lane.clr = restart;

  scfr_async_rx u_async (
    .ref_clk(ref_clk),
    .rst(rst),
    .lane(a_lane.eng),
    .bit_cyc(baud_reg)
  );

  scfr_sync_rx u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .lane(s_lane.eng),
    .bit_stb(bit_stb),
    .sync_chr(sync_reg),
    .two_sync(two_reg),
    .synced(synced)
  );

  // ----------------------------------------------------------------
  // Mode select
  // ----------------------------------------------------------------

  // Only the selected engine may deliver characters
  wire chr_stb = mode_s ? s_lane.stb : a_lane.stb;
  wire [7:0] chr_in = mode_s ? s_lane.chr : a_lane.chr;
  wire synced_act = mode_s & synced;

  // ----------------------------------------------------------------
  // Receive holding register
  // ----------------------------------------------------------------
  logic [7:0] data_reg;
  logic avail_reg;
  wire take = rd & sel_data;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_reg <= 8'h00;
      avail_reg <= 1'b0;
    end else begin
      // Old data is overwritten; the overrun flag reports the loss
      if (chr_stb) begin
        data_reg <= chr_in;
      end
      // A new character wins over a read in the same cycle
      if (chr_stb) begin
        avail_reg <= 1'b1;
      end else if (take) begin
        avail_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] ists_reg;
  logic synced_prev_reg;
  wire [IRQ_W-1:0] ev;
  wire [IRQ_W-1:0] w1c = (wr_b0 & sel_ists) ? wb_dat_i[IRQ_W-1:0] : '0;

  assign ev[IRQ_CHR] = chr_stb;
  // Overrun: previous character not yet taken when a new one lands
  assign ev[IRQ_OVR] = chr_stb & avail_reg & ~take;
  assign ev[IRQ_SYN] = synced_act & ~synced_prev_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      synced_prev_reg <= 1'b0;
    end else begin
      synced_prev_reg <= synced_act;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_ists
      // Set beats clear so no event is lost
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ists_reg[gi] <= 1'b0;
        end else if (ev[gi]) begin
          ists_reg[gi] <= 1'b1;
        end else if (w1c[gi]) begin
          ists_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Level output: stays high until software clears or masks the source
  assign irq = |(ists_reg & imsk_reg);

  // ----------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------
  logic [31:0] rdat_reg;
  wire [31:0] stat_w = {29'h0, mode_s, synced_act, avail_reg};
  // Read words, zero-extended; the hunt bit always reads back zero
  wire [31:0] rd_ctrl = {30'h0, two_reg, 1'b0};
  wire [31:0] rd_sync = {24'h0, sync_reg};
  wire [31:0] rd_data = {24'h0, data_reg};
  wire [31:0] rd_ists = {29'h0, ists_reg};
  wire [31:0] rd_imsk = {29'h0, imsk_reg};
  wire [31:0] rd_baud = {16'h0, baud_reg};
  wire [31:0] rd_mux =
    sel_ctrl ? rd_ctrl :
    sel_sync ? rd_sync :
    sel_data ? rd_data :
    sel_stat ? stat_w :
    sel_ists ? rd_ists :
    sel_imsk ? rd_imsk :
    sel_baud ? rd_baud : 32'h0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= acc;
      if (rd) begin
        rdat_reg <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

endmodule // scfr_top

// ==== verification/scfr_checks_assertions.sv ====
// Purpose: port-level checks of the framing receiver
// Assumes: one ref_clk domain, rst asynchronous and active high
// Notes: bound to scfr_top at the foot of this file

`timescale 1ns/1ps

module scfr_checks
  import scfr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [scfr_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Host side
  input wire logic mode_sync,
  input wire logic hunt_req,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  wire wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire stat_rd = rd_take && (wb_adr_i == ADR_STAT);

  ack_timely_a: assert property ((rd_take || wr_take) |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (!(rd_take || wr_take) |=> !wb_ack_o)
    else $error("ack without request");
  rdata_hold_a: assert property (!rd_take |=> $stable(wb_dat_o))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (rd_take && (wb_adr_i > ADR_BAUD || wb_adr_i[1:0] != 2'h0)
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  hunt_bit_a: assert property (rd_take && wb_adr_i == ADR_CTRL
    |=> !wb_dat_o[CTRL_HUNT])
    else $error("resync bit reads one");
  mode_flag_a: assert property ($stable(mode_sync)[*8] ##0 stat_rd
    |=> wb_dat_o[STAT_MODE] == $past(mode_sync))
    else $error("mode flag does not follow mode input");
  async_nosync_a: assert property ((!mode_sync)[*8] ##0 stat_rd
    |=> !wb_dat_o[STAT_SYNCED])
    else $error("synced flag set in async mode");
  hunt_clear_a: assert property (hunt_req[*3] ##0 stat_rd |=> !wb_dat_o[STAT_SYNCED])
    else $error("hunt request left receiver synced");
  irq_clear_a: assert property ($fell(irq)
    |-> $past(wr_take && (wb_adr_i == ADR_ISTS || wb_adr_i == ADR_IMSK)))
    else $error("interrupt dropped without status or mask write");
endmodule // scfr_checks

bind scfr_top scfr_checks u_checks (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .mode_sync, .hunt_req, .irq);

// ==== verification/scfr_remote_tx.sv ====
// Purpose: remote transmitter driving the receive line and clock
// Assumes: called from the bench, one frame at a time
// Notes: the line is not held between sync frames

`timescale 1ns/1ps

module scfr_remote_tx #(
  parameter int BIT_NS = 128
)(
  // Serial line
  output logic rx_data,
  output logic rx_clk
);
  initial begin
    rx_data = 1'b1;
    rx_clk = 1'b0;
  end

  task automatic send_async(input logic [7:0] c);
    rx_data = 1'b0;
    #(BIT_NS);
    for (int i = 7; i >= 0; i--) begin
      rx_data = c[i];
      #(BIT_NS);
    end
    rx_data = 1'b1;
    #(BIT_NS);
  endtask

  // Short dip, gone well before the half-bit recheck
  task automatic glitch();
    rx_data = 1'b0;
    #(BIT_NS / 4);
    rx_data = 1'b1;
    #(BIT_NS * 2);
  endtask

  // Clock runs only inside a frame; data moves on its falling edge
  task automatic send_sync(input logic [7:0] c, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      rx_data = c[i];
      #62.5 rx_clk = 1'b1;
      #62.5 rx_clk = 1'b0;
    end
    rx_data = ~rx_data;
  endtask
endmodule // scfr_remote_tx

// ==== verification/serial_char_framing_receiver_test.sv ====
// Purpose: register-level tests of the framing receiver
// Assumes: async bit period shortened to 16 cycles
// Notes: the remote model supplies both serial lines

`timescale 1ns/1ps

module serial_char_framing_receiver_test;
  import scfr_pkg::*;
  logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mode_sync, hunt_req, irq;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  wire rx_data, rx_clk;
  int n_mismatch = 0;
  int n_checks = 0;

  scfr_top #(.BIT_CYC(16'h0010)) dut (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_data, .rx_clk, .mode_sync,
    .hunt_req, .irq);
  scfr_remote_tx #(.BIT_NS(128)) far (.rx_data, .rx_clk);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) n_mismatch++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    check({31'h0, irq}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, mode_sync, hunt_req} = 5'h00;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rdchk(ADR_CTRL, 32'h0);
    rdchk(ADR_SYNC, {24'h0, SYNC_RST});
    rdchk(ADR_IMSK, 32'h0);
    rdchk(ADR_BAUD, 32'h10);
    rdchk(5'h1c, 32'h0);
    // Byte lane one disabled: only the low byte of the bit period lands
    wb_sel_i <= 4'h1;
    bus(1'b1, ADR_BAUD, 32'h0000ab20);
    wb_sel_i <= 4'hf;
    rdchk(ADR_BAUD, 32'h20);
    bus(1'b1, ADR_BAUD, 32'h10);
    rdchk(ADR_BAUD, 32'h10);
    $display("test reset done");
    bus(1'b1, ADR_IMSK, 32'h7);
    far.glitch();
    far.send_async(8'h81);
    wait_irq();
    rdchk(ADR_ISTS, 32'h1);
    rdchk(ADR_STAT, 32'h1);
    rdchk(ADR_DATA, 32'h81);
    rdchk(ADR_STAT, 32'h0);
    bus(1'b1, ADR_ISTS, 32'h1);
    check({31'h0, irq}, 32'h0);
    far.send_async(8'h00);
    far.send_async(8'hc3);
    repeat (20) @(posedge ref_clk);
    rdchk(ADR_ISTS, 32'h3);
    rdchk(ADR_DATA, 32'hc3);
    bus(1'b1, ADR_ISTS, 32'h7);
    $display("test async done");
    mode_sync <= 1'b1;
    repeat (10) @(posedge ref_clk);
    far.send_sync(8'h00, 8);
    far.send_sync(8'h05, 3);
    far.send_sync(8'h16, 8);
    far.send_sync(8'h3c, 8);
    repeat (10) @(posedge ref_clk);
    rdchk(ADR_ISTS, 32'h5);
    rdchk(ADR_STAT, 32'h7);
    rdchk(ADR_DATA, 32'h3c);
    bus(1'b1, ADR_IMSK, 32'h0);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, ADR_IMSK, 32'h7);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, ADR_ISTS, 32'h7);
    hunt_req <= 1'b1;
    @(posedge ref_clk);
    rdchk(ADR_STAT, 32'h4);
    hunt_req <= 1'b0;
    bus(1'b1, ADR_CTRL, 32'h3);
    rdchk(ADR_CTRL, 32'h2);
    far.send_sync(8'h16, 8);
    far.send_sync(8'h5a, 8);
    repeat (10) @(posedge ref_clk);
    rdchk(ADR_STAT, 32'h4);
    far.send_sync(8'h16, 8);
    far.send_sync(8'h16, 8);
    far.send_sync(8'he7, 8);
    repeat (10) @(posedge ref_clk);
    rdchk(ADR_DATA, 32'he7);
    mode_sync <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rdchk(ADR_STAT, 32'h0);
    $display("test sync done");
    conclude();
  end

  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule // serial_char_framing_receiver_test
